// ---- rtl/mq_write_port.sv ----
// Multi-queue write port with mode configuration and APB registers
// Summary of operation
// - Capture modes at master clear rising edge
// - Load offsets, counts, depths by chosen method
// - Mode pins pick standard/fall-through; word/packet is only latched and read back in REG_MODE
// - Standard: read flag low when queue empty
// - Standard: write flag low when queue full
// - Fall-through: read flag high when nothing readable
// - Fall-through: write flag low when writable
// - Strobe high at edge selects write queue
// - Selection ignores enable; writes stay on queue
// - Thirty-two queues share one write port
// - One word per edge, even during selection
// - Queue change spans four write cycles
// - Write enable low stores the input word
// - Full flag follows newly selected queue
// - Writes into a full queue are blocked
// - Flag strobe selects almost-full status quadrant
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
module mq_write_port (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [mq_pkg::APB_AW-1:0] paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           irq,
  input  wire logic                      master_clear_n,
  input  wire logic                      packet_select,
  input  wire logic                      fall_through_select,
  input  wire logic                      default_mode_sel,
  input  wire logic                      parallel_sel_n,
  input  wire logic                      default_offset_sel,
  input  wire logic                      expansion_sel,
  input  wire logic [2:0]                device_identity_pins,
  input  wire logic [7:0]                write_address_bus,
  input  wire logic                      write_address_strobe,
  input  wire logic                      flag_status_strobe,
  input  wire logic                      write_enable_n,
  input  wire logic [mq_pkg::DATA_W-1:0] write_data,
  output logic                           write_port_flag_n,
  output logic                           almost_full_flag_n,
  output logic      [7:0]                almost_full_status_bus,
  input  wire logic [mq_pkg::QW-1:0]     read_queue_sel,
  input  wire logic                      read_enable_n,
  output logic      [mq_pkg::DATA_W-1:0] read_data,
  output logic                           read_port_flag_n,
  output logic                           almost_empty_flag_n,
  output logic                           config_done_n
);
  import mq_pkg::*;

  function automatic logic id_match(input logic [7:0] addr, input logic [2:0] id);
    return addr[7:5] == id;
  endfunction

  function automatic prog_mode_t prog_decode(input logic dfm, input logic par_n);
    if (!dfm) begin
      return PROG_SERIAL;
    end
    return par_n ? PROG_DEFAULT : PROG_PARALLEL;
  endfunction

  queue_store_if qs ();

  queue_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .q       (qs)
  );

  // Pin synchronisers
  logic [PIN_W-1:0]  pin_s1_q;
  logic [PIN_W-1:0]  pin_s2_q;
  logic [1:0]        mclr_s_q;
  logic              mclr_prev_q;
  logic              mclr_rise;
  logic              s_pkt;
  logic              s_fall_through_select;
  logic              s_dfm;
  logic              s_par_n;
  logic              s_df;
  logic              s_exp;
  logic [2:0]        s_id;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q    <= '0;
      pin_s2_q    <= '0;
      mclr_s_q    <= '0;
      mclr_prev_q <= 1'b0;
    end else begin
      pin_s1_q    <= {device_identity_pins, expansion_sel, default_offset_sel,
                      parallel_sel_n, default_mode_sel, fall_through_select, packet_select};
      pin_s2_q    <= pin_s1_q;
      mclr_s_q    <= {mclr_s_q[0], master_clear_n};
      mclr_prev_q <= mclr_s_q[1];
    end
  end

  assign {s_id, s_exp, s_df, s_par_n, s_dfm, s_fall_through_select, s_pkt} = pin_s2_q;
  assign mclr_rise = mclr_s_q[1] && !mclr_prev_q;

  // Configuration state
  cfg_state_t        state_q;
  cfg_state_t        state_d;
  prog_mode_t        prog_q;
  logic              packet_q;
  logic              fall_through_select_q;
  logic              exp_q;
  logic [5:0]        load_cnt_q;
  logic [5:0]        qcount_q;
  logic [CNT_W-1:0]  depth_q;
  logic [CNT_W-1:0]  af_off_q;
  logic [CNT_W-1:0]  ae_off_q;
  logic              running;
  logic              flush;

  // APB decode
  logic              apb_setup;
  logic              apb_wr;
  logic [31:0]       rdata_d;
  logic              err_d;
  logic [31:0]       prdata_q;
  logic              pslverr_q;

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign running   = (state_q == CFG_RUN);
  assign flush     = (state_q == CFG_CLEAR);

  always_comb begin
    state_d = state_q;
    case (state_q)
      CFG_CLEAR: begin
        if (mclr_rise) begin
          state_d = (prog_decode(s_dfm, s_par_n) == PROG_SERIAL) ? CFG_PROGRAM : CFG_LOAD;
        end
      end
      CFG_LOAD: begin
        if (load_cnt_q == LOAD_CYCLES - 6'h01) begin
          state_d = CFG_RUN;
        end
      end
      CFG_PROGRAM: begin
        if (apb_wr && paddr == REG_CTRL && pwdata[0]) begin
          state_d = CFG_RUN;
        end
      end
      CFG_RUN: begin
        state_d = CFG_RUN;
      end
      default: begin
        state_d = CFG_CLEAR;
      end
    endcase
    if (!mclr_s_q[1]) begin
      state_d = CFG_CLEAR;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CFG_CLEAR;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_cnt_q <= '0;
    end else if (state_q == CFG_LOAD) begin
      load_cnt_q <= load_cnt_q + 6'h01;
    end else begin
      load_cnt_q <= '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_q   <= PROG_SERIAL;
      packet_q <= 1'b0;
      fall_through_select_q   <= 1'b0;
      exp_q    <= 1'b0;
    end else if (flush && mclr_rise) begin
      prog_q   <= prog_decode(s_dfm, s_par_n);
      packet_q <= s_pkt;
      fall_through_select_q   <= s_fall_through_select;
      exp_q    <= s_exp;
    end
  end

  // Write queue selection signals
  logic              id_ok;
  logic              sel_req;
  logic              quad_req;
  logic [QW-1:0]     pend_q;
  logic [QW-1:0]     active_q;
  logic              active_valid_q;
  logic [2:0]        chg_cnt_q;
  logic              chg_done;
  logic [1:0]        quad_q;

  assign id_ok = id_match(write_address_bus, s_id);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcount_q <= QCOUNT_MAX;
      depth_q  <= DEPTH_MAX;
      af_off_q <= OFFSET_LOW;
      ae_off_q <= OFFSET_LOW;
    end else if (flush && mclr_rise) begin
      qcount_q <= QCOUNT_MAX;
      depth_q  <= DEPTH_MAX;
      af_off_q <= s_df ? OFFSET_HIGH : OFFSET_LOW;
      ae_off_q <= s_df ? OFFSET_HIGH : OFFSET_LOW;
    end else if (state_q == CFG_LOAD && prog_q == PROG_PARALLEL) begin
      if (write_address_strobe && id_ok) begin
        qcount_q <= {1'b0, write_address_bus[4:0]} + 6'h01;
      end
    end else if (state_q == CFG_PROGRAM && apb_wr) begin
      case (paddr)
        REG_QCOUNT: begin
          if (pwdata[5:0] != '0 && pwdata[5:0] <= QCOUNT_MAX) begin
            qcount_q <= pwdata[5:0];
          end
        end
        REG_QDEPTH: begin
          if (pwdata[9:0] != '0 && pwdata[9:0] <= DEPTH_MAX) begin
            depth_q <= pwdata[9:0];
          end
        end
        REG_OFFSETS: begin
          af_off_q <= pwdata[CNT_W-1:0];
          ae_off_q <= pwdata[AE_OFF_LSB +: CNT_W];
        end
        default: begin
        end
      endcase
    end
  end

  assign sel_req  = running && write_address_strobe && id_ok &&
                    ({1'b0, write_address_bus[4:0]} < qcount_q);
  assign quad_req = running && !write_address_strobe && flag_status_strobe && id_ok;
  assign chg_done = !flush && !sel_req && (chg_cnt_q == 3'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q         <= '0;
      active_q       <= '0;
      active_valid_q <= 1'b0;
      chg_cnt_q      <= '0;
    end else if (flush) begin
      active_valid_q <= 1'b0;
      chg_cnt_q      <= '0;
    end else if (sel_req) begin
      pend_q    <= write_address_bus[4:0];
      chg_cnt_q <= CHANGE_CYCLES - 3'h1;
    end else if (chg_cnt_q != '0) begin
      chg_cnt_q <= chg_cnt_q - 3'h1;
      if (chg_done) begin
        active_q       <= pend_q;
        active_valid_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quad_q <= '0;
    end else if (quad_req) begin
      quad_q <= write_address_bus[1:0];
    end
  end

  // Write and read paths
  logic              wr_try;
  logic              wr_go;
  logic              wr_blocked;
  logic              full_sel;
  logic              empty_sel;

  assign wr_try     = running && active_valid_q && !write_enable_n;
  assign wr_go      = wr_try && !qs.full[active_q];
  assign wr_blocked = wr_try && qs.full[active_q];
  assign full_sel   = !running || !active_valid_q || qs.full[active_q];
  assign empty_sel  = !running || qs.empty[read_queue_sel];

  assign qs.flush    = flush;
  assign qs.wr_en    = wr_go;
  assign qs.wr_queue = active_q;
  assign qs.wr_data  = write_data;
  assign qs.rd_en    = running && !read_enable_n && !qs.empty[read_queue_sel];
  assign qs.rd_queue = read_queue_sel;
  assign qs.depth    = depth_q;
  assign qs.af_off   = af_off_q;
  assign qs.ae_off   = ae_off_q;
  assign read_data   = qs.rd_data;

  // Flag outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_port_flag_n      <= 1'b0;
      read_port_flag_n       <= 1'b0;
      almost_full_flag_n     <= 1'b1;
      almost_empty_flag_n    <= 1'b0;
      almost_full_status_bus <= 8'hff;
      config_done_n          <= 1'b1;
    end else begin
      write_port_flag_n      <= fall_through_select_q ? full_sel : !full_sel;
      read_port_flag_n       <= fall_through_select_q ? empty_sel : !empty_sel;
      almost_full_flag_n     <= !(active_valid_q && qs.almost_full[active_q]);
      almost_empty_flag_n    <= !qs.almost_empty[read_queue_sel];
      almost_full_status_bus <= ~qs.almost_full[{quad_q, 3'h0} +: 8];
      config_done_n          <= (state_d != CFG_RUN);
    end
  end

  // Interrupt status and mask
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [IRQ_W-1:0]  irq_evt;
  logic [IRQ_W-1:0]  irq_clr;

  always_comb begin
    irq_evt              = '0;
    irq_evt[IRQ_BLOCKED] = wr_blocked;
    irq_evt[IRQ_QCHANGE] = chg_done;
    irq_evt[IRQ_CFGDONE] = (state_q != CFG_RUN) && (state_d == CFG_RUN);
    irq_evt[IRQ_MCLEAR]  = mclr_rise;
  end

  assign irq_clr = (apb_wr && paddr == REG_IRQ_STATUS) ? pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= '0;
    end else if (apb_wr && paddr == REG_IRQ_MASK) begin
      irq_mask_q <= pwdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Register read mux
  always_comb begin
    rdata_d = '0;
    err_d   = 1'b0;
    case (paddr)
      REG_CTRL:       rdata_d[1:0] = state_q;
      REG_MODE:       rdata_d[5:0] = {running, exp_q, prog_q, fall_through_select_q, packet_q};
      REG_QCOUNT:     rdata_d[5:0] = qcount_q;
      REG_QDEPTH:     rdata_d[CNT_W-1:0] = depth_q;
      REG_OFFSETS:    rdata_d = {6'h00, ae_off_q, 6'h00, af_off_q};
      REG_WSTATUS:    rdata_d[9:0] = {quad_q, 1'b0, chg_cnt_q != '0, active_valid_q, active_q};
      REG_FULL:       rdata_d = qs.full;
      REG_EMPTY:      rdata_d = qs.empty;
      REG_IRQ_STATUS: rdata_d[IRQ_W-1:0] = irq_stat_q;
      REG_IRQ_MASK:   rdata_d[IRQ_W-1:0] = irq_mask_q;
      default:        err_d = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr_q <= err_d;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  assign pready  = 1'b1;
endmodule

// ---- pkg/mq_pkg.sv ----
// Constants and types shared by the multi-queue write port design
package mq_pkg;
  localparam int NUM_QUEUES = 32;
  localparam int QW         = 5;
  localparam int DATA_W     = 36;
  localparam int PTR_W      = 9;
  localparam int CNT_W      = 10;
  localparam int APB_AW     = 8;
  localparam int PIN_W      = 9;

  localparam logic [CNT_W-1:0] DEPTH_MAX     = 10'h200;
  localparam logic [CNT_W-1:0] OFFSET_LOW    = 10'h008;
  localparam logic [CNT_W-1:0] OFFSET_HIGH   = 10'h080;
  localparam logic [5:0]       QCOUNT_MAX    = 6'h20;
  localparam logic [2:0]       CHANGE_CYCLES = 3'h4;
  localparam logic [5:0]       LOAD_CYCLES   = 6'h20;

  localparam logic [APB_AW-1:0] REG_CTRL       = 8'h00;
  localparam logic [APB_AW-1:0] REG_MODE       = 8'h04;
  localparam logic [APB_AW-1:0] REG_QCOUNT     = 8'h08;
  localparam logic [APB_AW-1:0] REG_QDEPTH     = 8'h0c;
  localparam logic [APB_AW-1:0] REG_OFFSETS    = 8'h10;
  localparam logic [APB_AW-1:0] REG_WSTATUS    = 8'h14;
  localparam logic [APB_AW-1:0] REG_FULL       = 8'h18;
  localparam logic [APB_AW-1:0] REG_EMPTY      = 8'h1c;
  localparam logic [APB_AW-1:0] REG_IRQ_STATUS = 8'h20;
  localparam logic [APB_AW-1:0] REG_IRQ_MASK   = 8'h24;

  localparam int IRQ_W       = 4;
  localparam int IRQ_BLOCKED = 0;
  localparam int IRQ_QCHANGE = 1;
  localparam int IRQ_CFGDONE = 2;
  localparam int IRQ_MCLEAR  = 3;
  localparam int AE_OFF_LSB  = 16;

  typedef enum logic [1:0] {PROG_SERIAL, PROG_PARALLEL, PROG_DEFAULT} prog_mode_t;
  typedef enum logic [1:0] {CFG_CLEAR, CFG_LOAD, CFG_PROGRAM, CFG_RUN} cfg_state_t;
endpackage

// ---- pkg/queue_store_if.sv ----
// Interface between the port control and the queue storage
`timescale 1ns/1ps
interface queue_store_if;
  logic                         flush;
  logic                         wr_en;
  logic [mq_pkg::QW-1:0]        wr_queue;
  logic [mq_pkg::DATA_W-1:0]    wr_data;
  logic                         rd_en;
  logic [mq_pkg::QW-1:0]        rd_queue;
  logic [mq_pkg::DATA_W-1:0]    rd_data;
  logic [mq_pkg::CNT_W-1:0]     depth;
  logic [mq_pkg::CNT_W-1:0]     af_off;
  logic [mq_pkg::CNT_W-1:0]     ae_off;
  logic [mq_pkg::NUM_QUEUES-1:0] full;
  logic [mq_pkg::NUM_QUEUES-1:0] empty;
  logic [mq_pkg::NUM_QUEUES-1:0] almost_full;
  logic [mq_pkg::NUM_QUEUES-1:0] almost_empty;

  modport store (input flush, wr_en, wr_queue, wr_data, rd_en, rd_queue, depth, af_off, ae_off,
                 output rd_data, full, empty, almost_full, almost_empty);
  modport ctrl  (output flush, wr_en, wr_queue, wr_data, rd_en, rd_queue, depth, af_off, ae_off,
                 input rd_data, full, empty, almost_full, almost_empty);
endinterface

// ---- rtl/queue_store.sv ----
// Queue storage: shared memory with per-queue pointers, counts and flags
`timescale 1ns/1ps
module queue_store (
  input wire logic    pclk,
  input wire logic    presetn,
  queue_store_if.store q
);
  import mq_pkg::*;

  logic [DATA_W-1:0]     mem [NUM_QUEUES*512];
  logic [DATA_W-1:0]     rd_data_q;
  wire  [PTR_W-1:0]      wp_w [NUM_QUEUES];
  wire  [PTR_W-1:0]      rp_w [NUM_QUEUES];
  wire  [NUM_QUEUES-1:0] full_w;
  wire  [NUM_QUEUES-1:0] empty_w;
  wire  [NUM_QUEUES-1:0] afull_w;
  wire  [NUM_QUEUES-1:0] aempty_w;

  for (genvar g = 0; g < NUM_QUEUES; g++) begin : g_q
    logic [PTR_W-1:0] wp_q;
    logic [PTR_W-1:0] rp_q;
    logic [CNT_W-1:0] cnt_q;
    wire              wi = q.wr_en && (q.wr_queue == QW'(g));
    wire              ri = q.rd_en && (q.rd_queue == QW'(g));
    wire              w_wrap = ({1'b0, wp_q} == q.depth - 10'h001);
    wire              r_wrap = ({1'b0, rp_q} == q.depth - 10'h001);

    // Pointers wrap at the programmed depth
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        wp_q  <= '0;
        rp_q  <= '0;
        cnt_q <= '0;
      end else if (q.flush) begin
        wp_q  <= '0;
        rp_q  <= '0;
        cnt_q <= '0;
      end else begin
        if (wi) begin
          wp_q <= w_wrap ? '0 : wp_q + 9'h001;
        end
        if (ri) begin
          rp_q <= r_wrap ? '0 : rp_q + 9'h001;
        end
        cnt_q <= cnt_q + CNT_W'(wi) - CNT_W'(ri);
      end
    end

    assign wp_w[g]     = wp_q;
    assign rp_w[g]     = rp_q;
    assign full_w[g]   = (cnt_q >= q.depth);
    assign afull_w[g]  = ({1'b0, cnt_q} + {1'b0, q.af_off} >= {1'b0, q.depth});
    assign empty_w[g]  = (cnt_q == '0);
    assign aempty_w[g] = (cnt_q <= q.ae_off);
  end

  // Word storage
  always_ff @(posedge pclk) begin
    if (q.wr_en) begin
      mem[{q.wr_queue, wp_w[q.wr_queue]}] <= q.wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_q <= '0;
    end else if (q.rd_en) begin
      rd_data_q <= mem[{q.rd_queue, rp_w[q.rd_queue]}];
    end
  end

  assign q.rd_data      = rd_data_q;
  assign q.full         = full_w;
  assign q.empty        = empty_w;
  assign q.almost_full  = afull_w;
  assign q.almost_empty = aempty_w;
endmodule

// ---- tb/mq_write_port_asserts.sv ----
// Pin-level assertions for the multi-queue write port
`timescale 1ns/1ps
module mq_write_port_asserts (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       master_clear_n,
  input wire logic       default_mode_sel,
  input wire logic       fall_through_select,
  input wire logic [2:0] device_identity_pins,
  input wire logic [7:0] write_address_bus,
  input wire logic       write_address_strobe,
  input wire logic       flag_status_strobe,
  input wire logic       write_enable_n,
  input wire logic       read_enable_n,
  input wire logic       write_port_flag_n,
  input wire logic       read_port_flag_n,
  input wire logic [7:0] almost_full_status_bus,
  input wire logic       config_done_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic calm;
  logic quiet;
  assign calm  = master_clear_n && !config_done_n && read_enable_n && !write_address_strobe;
  assign quiet = calm && write_enable_n && !flag_status_strobe;
  sequence sel_cycle;
    quiet [*4] ##1 write_address_strobe && write_address_bus[7:5] == device_identity_pins && write_enable_n;
  endsequence
  sequence sel_wait;
    sel_cycle ##1 quiet [*3];
  endsequence
  a_clear_done: assert property (!master_clear_n [*6] |-> config_done_n)
    else $error("done shown in clear");
  a_load_span: assert property ($rose(master_clear_n) && default_mode_sel
    |-> config_done_n [*8] ##[24:32] !config_done_n) else $error("load length wrong");
  a_run_stays: assert property (!config_done_n && master_clear_n |=> !config_done_n)
    else $error("run state lost");
  a_idle_flags: assert property (quiet [*6] |-> $stable(write_port_flag_n) && $stable(read_port_flag_n))
    else $error("flag moved while idle");
  a_bus_idle: assert property (quiet [*6] |-> $stable(almost_full_status_bus))
    else $error("status bus moved while idle");
  a_full_sticks: assert property ((calm && !fall_through_select) [*5] ##0 !write_port_flag_n
    |=> !write_port_flag_n) else $error("full queue took a write");
  a_fall_through_select_hold: assert property ((calm && fall_through_select) [*5] ##0 write_port_flag_n
    |=> write_port_flag_n) else $error("ready without room");
  a_switch_hold: assert property (sel_wait |-> write_port_flag_n == $past(write_port_flag_n, 4))
    else $error("queue switched early");
endmodule
bind mq_write_port mq_write_port_asserts u_chk (.pclk, .presetn, .master_clear_n, .default_mode_sel,
  .fall_through_select, .device_identity_pins, .write_address_bus, .write_address_strobe, .flag_status_strobe,
  .write_enable_n, .read_enable_n, .write_port_flag_n, .read_port_flag_n, .almost_full_status_bus,
  .config_done_n);

// ---- tb/upstream_writer.sv ----
// Upstream writer model feeding the write port
`timescale 1ns/1ps
module upstream_writer (
  input  wire logic                      pclk,
  output logic      [7:0]                write_address_bus,
  output logic                           write_address_strobe,
  output logic                           flag_status_strobe,
  output logic                           write_enable_n,
  output logic      [mq_pkg::DATA_W-1:0] write_data
);
  import mq_pkg::*;
  int seed = 47;
  initial begin
    write_address_bus = 8'h00;
    write_address_strobe = 1'b0;
    flag_status_strobe = 1'b0;
    write_enable_n = 1'b1;
    write_data = '0;
  end
  // address held through the strobe cycle
  // one word per edge while enabled
  task cyc(input logic s, input logic f, input logic [7:0] a, input logic wen);
    write_address_strobe <= s;
    flag_status_strobe <= f;
    write_address_bus <= (s || f) ? a : ~write_address_bus;
    write_enable_n <= wen;
    write_data <= wen ? ~write_data : DATA_W'({$random(seed), $random(seed)});
    @(posedge pclk);
  endtask
  task idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 8'h00, 1'b1);
  endtask
endmodule

// ---- tb/mq_write_port_tb.sv ----
// Self-checking bench for the multi-queue write port
`timescale 1ns/1ps
module mq_write_port_tb;
  import mq_pkg::*;
  localparam logic [2:0] ID = 3'h5;
  typedef struct {int k; logic [31:0] v;} note_t;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, mcn, pkt, fts, dos;
  logic              was, fss, wen, wpf, aff, ren, rpf, aef, cdn, dms, psn, exs;
  logic [2:0]        idp;
  logic [4:0]        rqs;
  logic [7:0]        paddr, wab, afsb;
  logic [31:0]       pwdata, prdata;
  logic [DATA_W-1:0] wd, rdat;
  note_t             q[$];
  event              look;
  int                err_total = 0;
  int                checks = 0;
  int                cyc_n = 0;
  logic [7:0]        ra [7] = '{REG_CTRL, REG_MODE, REG_QCOUNT, REG_QDEPTH, REG_OFFSETS, REG_IRQ_STATUS, 8'h40};
  logic [31:0]       rv [7] = '{32'h3, 32'h29, 32'h20, 32'h200, 32'h80008, 32'hc, 32'h0};

  mq_write_port dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .master_clear_n(mcn), .packet_select(pkt), .fall_through_select(fts), .default_mode_sel(dms),
    .parallel_sel_n(psn), .default_offset_sel(dos), .expansion_sel(exs), .device_identity_pins(idp),
    .write_address_bus(wab), .write_address_strobe(was), .flag_status_strobe(fss), .write_enable_n(wen),
    .write_data(wd), .write_port_flag_n(wpf), .almost_full_flag_n(aff), .almost_full_status_bus(afsb),
    .read_queue_sel(rqs), .read_enable_n(ren), .read_data(rdat), .read_port_flag_n(rpf),
    .almost_empty_flag_n(aef), .config_done_n(cdn));
  upstream_writer up (.pclk(pclk), .write_address_bus(wab), .write_address_strobe(was),
    .flag_status_strobe(fss), .write_enable_n(wen), .write_data(wd));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task stop_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task note(input int k, input logic [31:0] v);
    q.push_back('{k, v});
    ->look;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rreg(input logic [7:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0);
    note(3, v);
  endtask

  task start();
    int k;
    k = 0;
    mcn <= 1'b1;
    up.idle(1);
    while (cdn !== 1'b0 && k < 100) begin
      up.idle(1);
      k++;
    end
    note(6, 0);
  endtask

  // Compares each outcome against the oldest note
  initial begin
    note_t n;
    logic [31:0] s;
    forever begin
      @(look);
      #1;
      while (q.size() > 0) begin
        n = q.pop_front();
        case (n.k)
          0: s = {31'h0, wpf};
          1: s = {31'h0, rpf};
          2: s = {24'h0, afsb};
          3: s = prdata;
          4: s = {31'h0, pslverr};
          5: s = {31'h0, irq};
          7: s = {31'h0, aff};
          8: s = {31'h0, aef};
          default: s = {31'h0, cdn};
        endcase
        chk(s, n.v);
      end
    end
  end

  always @(posedge pclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 4000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mcn = 1'b0;
    pkt = 1'b1;
    fts = 1'b0;
    dos = 1'b0;
    ren = 1'b1;
    dms = 1'b1;
    psn = 1'b1;
    exs = 1'b0;
    idp = ID;
    rqs = 5'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    up.idle(4);
    start();
    note(1, 0);
    apb(1'b1, REG_MODE, 32'h0);
    apb(1'b1, 8'h40, 32'h1);
    for (int i = 0; i < 7; i++) rreg(ra[i], rv[i]);
    note(4, 1);
    note(5, 0);
    apb(1'b1, REG_IRQ_MASK, 32'hf);
    note(5, 1);
    apb(1'b1, REG_IRQ_STATUS, 32'hf);
    note(5, 0);
    up.cyc(1'b1, 1'b0, {ID, 5'd0}, 1'b1);
    up.idle(4);
    note(0, 1);
    repeat (511) up.cyc(1'b0, 1'b0, 8'h00, 1'b0);
    up.idle(2);
    note(0, 1);
    apb(1'b1, REG_IRQ_STATUS, 32'hf);
    up.cyc(1'b0, 1'b0, 8'h00, 1'b0);
    up.idle(2);
    note(0, 0);
    note(5, 0);
    up.cyc(1'b0, 1'b0, 8'h00, 1'b0);
    up.idle(2);
    note(5, 1);
    up.cyc(1'b1, 1'b0, {ID, 5'd1}, 1'b0);
    for (int i = 1; i < 6; i++) begin
      up.cyc(1'b0, 1'b0, 8'h00, 1'b0);
      note(0, (i > 3));
    end
    up.cyc(1'b1, 1'b0, {3'h2, 5'd0}, 1'b1);
    up.idle(5);
    note(0, 1);
    for (int i = 3; i >= 0; i--) begin
      up.cyc(1'b0, 1'b1, {ID, 3'h0, i[1:0]}, 1'b1);
      up.idle(2);
      note(2, (i == 0) ? 32'hfe : 32'hff);
    end
    up.cyc(1'b0, 1'b1, {3'h2, 5'd1}, 1'b1);
    up.idle(4);
    note(2, 32'hfe);
    up.cyc(1'b1, 1'b0, {ID, 5'd0}, 1'b1);
    up.idle(4);
    note(0, 0);
    note(7, 0);
    note(8, 1);
    ren <= 1'b0;
    up.idle(1);
    ren <= 1'b1;
    up.idle(3);
    note(0, 1);
    note(1, 1);
    mcn <= 1'b0;
    fts <= 1'b1;
    pkt <= 1'b0;
    dos <= 1'b1;
    up.idle(8);
    start();
    rreg(REG_MODE, 32'h2a);
    rreg(REG_OFFSETS, 32'h0080_0080);
    note(1, 1);
    up.cyc(1'b1, 1'b0, {ID, 5'd31}, 1'b1);
    up.idle(4);
    note(0, 0);
    up.idle(2);
    stop_test();
  end
endmodule
